// ===== hw/eeprom_access_control.sv
// data eeprom access controller: address/data/control registers, read stall, timed write
`timescale 1ns/1ps
module eeprom_access_control #(
    parameter int WRITE_RC_COUNT = nv_access_pkg::WRITE_RC_CYCLES,
    parameter int ADDR_WIDTH = nv_access_pkg::ADDR_W
) (
    input wire logic clk, // 20 MHz core clock
    input wire logic reset, // synchronous, active high
    input wire logic rc_osc, // calibrated rc oscillator, asynchronous
    input wire logic global_irq_enable, // core global interrupt flag
    input wire nv_access_pkg::cpu_write_t cpu_wr, // software register writes
    input wire logic [7:0] array_rdata, // byte at array_addr, combinational from array
    output logic [nv_access_pkg::ADDR_W-1:0] array_addr, // linear byte address
    output nv_access_pkg::nv_cmd_t array_cmd, // write command contents
    output logic array_prog, // high while the array is being programmed
    output logic [7:0] nv_data_reg, // data register contents
    output logic [nv_access_pkg::ADDR_W-1:0] nv_address_reg, // address register
    output logic [1:0] program_mode_field, // mode field
    output logic program_arm_bit, // arm bit
    output logic program_strobe_bit, // program strobe, high while writing
    output logic ready_irq_enable, // interrupt enable bit
    output logic ready_irq, // level ready interrupt
    output logic cpu_stall // halts the core
);
    import nv_access_pkg::*;

    // elaboration checks: the counters below are sized for these limits only
    if (ADDR_WIDTH != ADDR_W || ADDR_W < 9 || ADDR_W > 16) begin
        $error("address width must match the package and split into two bytes");
    end
    if (WRITE_RC_COUNT < 1) begin
        $error("write time must be at least one oscillator cycle");
    end
    if (ARM_CYCLES < 1 || ARM_CYCLES > 8) begin
        $error("arm window does not fit its counter");
    end
    if (READ_STALL_CYCLES < 1 || READ_STALL_CYCLES > 7 || WRITE_STALL_CYCLES < 1
        || WRITE_STALL_CYCLES > 7) begin
        $error("stall lengths do not fit the stall counter");
    end

    // control write bit positions
    localparam int BIT_READ = 0;
    localparam int BIT_PROG = 1;
    localparam int BIT_ARM = 2;
    localparam int BIT_IRQ = 3;
    localparam int BIT_MODE = 4;
    // counter width follows the parameter, so a longer write time only widens rc_cnt_r
    localparam int RC_W = $clog2(WRITE_RC_COUNT + 1);
    localparam logic [RC_W-1:0] RC_LAST = RC_W'(WRITE_RC_COUNT - 1);
    localparam logic [2:0] ARM_LAST = 3'(ARM_CYCLES - 1);
    localparam logic [2:0] READ_STALL = 3'(READ_STALL_CYCLES);
    localparam logic [2:0] WRITE_STALL = 3'(WRITE_STALL_CYCLES);

    // internal state; all outputs but ready_irq and cpu_stall are one-cycle copies of it
    logic [ADDR_W-1:0] addr_r;
    logic [7:0] data_r;
    logic [1:0] mode_r;
    logic arm_r;
    logic [2:0] arm_cnt_r;
    logic busy_r;
    logic irq_en_r;
    logic [2:0] stall_cnt_r;
    logic rc_s1_r;
    logic rc_s2_r;
    logic rc_s3_r;
    logic [RC_W-1:0] rc_cnt_r;
    logic rc_tick;
    logic read_req;
    logic prog_req;
    logic write_done;

    // oscillator crosses by two flops; nothing but the second flop reads the first
    always_ff @(posedge clk) begin
        rc_s1_r <= rc_osc;
        rc_s2_r <= rc_s1_r;
    end

    // edge stage behind the synchroniser: one tick per rising oscillator edge
    always_ff @(posedge clk) begin
        rc_s3_r <= rc_s2_r;
    end
    assign rc_tick = rc_s2_r & ~rc_s3_r;

    // the array sees the address one cycle late, so software must leave at least one
    // cycle between the last address write and the read strobe
    assign read_req = cpu_wr.ctrl_we & cpu_wr.wdata[BIT_READ] & ~busy_r;
    assign prog_req = cpu_wr.ctrl_we & cpu_wr.wdata[BIT_PROG] & arm_r & ~busy_r;
    assign write_done = busy_r & rc_tick & (rc_cnt_r == RC_LAST);

    // address register; no reset value, kept through reset when busy
    always_ff @(posedge clk) begin
        if (!busy_r) begin
            if (cpu_wr.addr_high_we) begin
                addr_r[ADDR_W-1:8] <= cpu_wr.wdata[ADDR_HIGH_W-1:0];
            end
            if (cpu_wr.addr_low_we) begin
                addr_r[7:0] <= cpu_wr.wdata;
            end
        end
    end

    // data register: software write or captured read byte
    // a read strobe wins over a data write in the same cycle
    always_ff @(posedge clk) begin
        if (reset && !busy_r) begin
            data_r <= DATA_RESET;
        end else if (read_req) begin
            data_r <= array_rdata;
        end else if (cpu_wr.data_we && !busy_r) begin
            data_r <= cpu_wr.wdata;
        end
    end

    // write engine survives reset so a started write always completes
    // reset only clears an idle engine; the count restarts at zero on each strobe
    always_ff @(posedge clk) begin
        if (write_done) begin
            busy_r <= 1'b0;
            rc_cnt_r <= '0;
        end else if (busy_r) begin
            if (rc_tick) begin
                rc_cnt_r <= rc_cnt_r + 1'b1;
            end
        end else if (reset) begin
            busy_r <= 1'b0;
            rc_cnt_r <= '0;
        end else if (prog_req) begin
            busy_r <= 1'b1;
            rc_cnt_r <= '0;
        end
    end

    // mode field frozen while a write runs
    always_ff @(posedge clk) begin
        if (reset && !busy_r) begin
            mode_r <= MODE_RESET;
        end else if (cpu_wr.ctrl_we && !busy_r) begin
            mode_r <= cpu_wr.wdata[BIT_MODE+1:BIT_MODE];
        end
    end

    // the enable may change during a write; only the ready level is held off by busy
    always_ff @(posedge clk) begin
        if (reset) begin
            irq_en_r <= 1'b0;
        end else if (cpu_wr.ctrl_we) begin
            irq_en_r <= cpu_wr.wdata[BIT_IRQ];
        end
    end

    // arm window: a program strobe only counts within four cycles of arming
    // arming again restarts the window, since the set wins over expiry
    always_ff @(posedge clk) begin
        if (reset) begin
            arm_r <= 1'b0;
            arm_cnt_r <= '0;
        end else if (cpu_wr.ctrl_we && cpu_wr.wdata[BIT_ARM] && !cpu_wr.wdata[BIT_PROG]) begin
            arm_r <= 1'b1;
            arm_cnt_r <= '0;
        end else if (prog_req) begin
            arm_r <= 1'b0;
        end else if (arm_r) begin
            arm_cnt_r <= arm_cnt_r + 1'b1;
            if (arm_cnt_r == ARM_LAST) begin
                arm_r <= 1'b0;
            end
        end
    end

    // core stall: four cycles after a read, two after a write start
    always_ff @(posedge clk) begin
        if (reset) begin
            stall_cnt_r <= '0;
        end else if (read_req) begin
            stall_cnt_r <= READ_STALL;
        end else if (prog_req) begin
            stall_cnt_r <= WRITE_STALL;
        end else if (stall_cnt_r != 3'h0) begin
            stall_cnt_r <= stall_cnt_r - 1'b1;
        end
    end

    // stall is registered, so the core sees it from the cycle after the strobe
    always_ff @(posedge clk) begin
        if (reset) begin
            cpu_stall <= 1'b0;
        end else begin
            cpu_stall <= read_req | prog_req | (stall_cnt_r > 3'h1);
        end
    end

    // ready comes from busy through one flop, like the program strobe copy,
    // so with both interrupt enables on the two outputs agree, except in the cycle after a reset, which clears ready_irq but not the strobe copy
    always_ff @(posedge clk) begin
        if (reset) begin
            ready_irq <= 1'b0;
        end else begin
            ready_irq <= irq_en_r & global_irq_enable & ~busy_r;
        end
    end

    // array side: address, write contents and programming flag
    always_ff @(posedge clk) begin
        array_addr <= addr_r;
        array_cmd <= '{addr: addr_r, data: data_r, mode: prog_mode_t'(mode_r)};
        array_prog <= busy_r;
    end

    // register copies: not reset, so a write in flight keeps showing through a reset
    always_ff @(posedge clk) begin
        nv_data_reg <= data_r;
        nv_address_reg <= addr_r;
        program_mode_field <= mode_r;
    end

    // control bit copies
    always_ff @(posedge clk) begin
        program_arm_bit <= arm_r;
        program_strobe_bit <= busy_r;
        ready_irq_enable <= irq_en_r;
    end
endmodule

// ===== hw/nv_access_pkg.sv
// constants and carrier types for the data eeprom access controller
//
// Behaviour
// - A read strobe with a held address loads the addressed byte into the data register in one access.
// - Every read stalls the processor for four cycles before the next instruction.
// - While a write runs, read strobes are ignored and address writes are discarded.
// - A write is timed by counting 26,368 cycles of the calibrated RC oscillator, about 3.3 ms.
// - A reset during a write lets the write run to completion.
// - The arm bit clears itself four cycles after being set; a program strobe counts only while it is set.
// - The program strobe bit clears itself when the write time has elapsed.
// - The mode field picks erase+write, erase only or write only, and is frozen during a write.
// - With the enable and global interrupts on, the ready interrupt is a level while no write runs.
package nv_access_pkg;
    localparam int ADDR_W = 12;
    localparam int ARM_CYCLES = 4;
    localparam int READ_STALL_CYCLES = 4;
    localparam int WRITE_STALL_CYCLES = 2;
    localparam int WRITE_RC_CYCLES = 26368;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [1:0] MODE_RESET = 2'h0;
    localparam int ADDR_HIGH_W = ADDR_W - 8;

    typedef enum logic [1:0] {
        mode_erase_write,
        mode_erase_only,
        mode_write_only,
        mode_reserved
    } prog_mode_t;

    // one write cycle toward the array
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0] data;
        prog_mode_t mode;
    } nv_cmd_t;

    // software side control strobes, each a one-cycle pulse
    typedef struct packed {
        logic addr_high_we;
        logic addr_low_we;
        logic data_we;
        logic ctrl_we;
        logic [7:0] wdata;
    } cpu_write_t;
endpackage

// ===== verification/eeprom_access_control_checker.sv
// port-level assertions for the eeprom access controller
`timescale 1ns/1ps
module eeprom_access_control_checker (
    input wire logic clk, // core clock
    input wire logic reset, // synchronous reset
    input wire logic global_irq_enable, // core interrupt flag
    input wire nv_access_pkg::cpu_write_t cpu_wr, // register writes
    input wire logic [7:0] array_rdata, // array byte
    input wire logic [7:0] nv_data_reg, // data register
    input wire logic [nv_access_pkg::ADDR_W-1:0] nv_address_reg, // address register
    input wire logic [1:0] program_mode_field, // mode field
    input wire logic program_arm_bit, // arm bit
    input wire logic program_strobe_bit, // busy flag
    input wire logic ready_irq_enable, // interrupt enable
    input wire logic ready_irq, // ready interrupt
    input wire logic cpu_stall // core halt
);
    import nv_access_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    logic rd_req;
    assign rd_req = cpu_wr.ctrl_we && cpu_wr.wdata[0] && !program_strobe_bit;
    // a ctrl write just before hides a write start that the copies do not show yet
    sequence s_quiet_read;
        rd_req && !$past(cpu_wr.ctrl_we) && !$past(cpu_wr.ctrl_we, 2);
    endsequence
    sequence s_read_stall;
        cpu_stall [*4] ##1 !cpu_stall;
    endsequence
    // the stall starts one cycle before the strobe copy rises, so its first cycle is past
    sequence s_write_stall;
        $past(cpu_stall) && !$past(cpu_stall, 2) && cpu_stall ##1 !cpu_stall;
    endsequence
    a_read_stall: assert property (s_quiet_read |=> s_read_stall)
        else $error("read stall length wrong");
    a_read_data: assert property (s_quiet_read |=> ##1 nv_data_reg == $past(array_rdata, 2))
        else $error("read byte not captured");
    a_arm_expiry: assert property ($rose(program_arm_bit) |-> ##[2:5] !program_arm_bit)
        else $error("arm bit did not expire");
    a_arm_needed: assert property ($rose(program_strobe_bit) |->
        program_arm_bit || $past(program_arm_bit) || $past(program_arm_bit, 2))
        else $error("write started without arm");
    // a reset in the stall cycle clears the stall along with the core
    a_write_stall: assert property ($rose(program_strobe_bit) && !$past(reset)
        |-> s_write_stall)
        else $error("write stall length wrong");
    a_addr_frozen: assert property (program_strobe_bit && $past(program_strobe_bit)
        && $past(program_strobe_bit, 2) |-> $stable(nv_address_reg))
        else $error("address changed during write");
    a_mode_frozen: assert property (program_strobe_bit && $past(program_strobe_bit)
        && $past(program_strobe_bit, 2) |-> $stable(program_mode_field))
        else $error("mode changed during write");
    a_irq_level: assert property ((ready_irq_enable && global_irq_enable
        && !program_strobe_bit) [*3] |-> ready_irq)
        else $error("ready interrupt missing");
    a_irq_busy: assert property (program_strobe_bit && $past(program_strobe_bit) |-> !ready_irq)
        else $error("ready interrupt during write");
endmodule
bind eeprom_access_control eeprom_access_control_checker u_chk (.clk(clk), .reset(reset),
    .global_irq_enable(global_irq_enable), .cpu_wr(cpu_wr), .array_rdata(array_rdata),
    .nv_data_reg(nv_data_reg), .nv_address_reg(nv_address_reg),
    .program_mode_field(program_mode_field), .program_arm_bit(program_arm_bit),
    .program_strobe_bit(program_strobe_bit), .ready_irq_enable(ready_irq_enable),
    .ready_irq(ready_irq), .cpu_stall(cpu_stall));

// ===== verification/eeprom_access_control_tb_top.sv
// self-checking bench for the eeprom access controller
`timescale 1ns/1ps
module eeprom_access_control_tb_top;
    import nv_access_pkg::*;
    logic clk = 0, reset = 1, rc_osc = 0, global_irq_enable = 1;
    cpu_write_t cpu_wr = '0;
    logic [7:0] array_rdata, nv_data_reg;
    logic [ADDR_W-1:0] array_addr, nv_address_reg;
    nv_cmd_t array_cmd;
    logic [1:0] program_mode_field;
    logic array_prog, program_arm_bit, program_strobe_bit, ready_irq_enable, ready_irq, cpu_stall;
    int err_total = 0, checks_done = 0, cyc = 0, n;
    initial forever #25 clk = ~clk;
    // rc runs slower than and unrelated to the core clock
    initial forever #70 rc_osc = ~rc_osc;
    nv_array_model u_nv_array_model (.array_addr(array_addr), .array_rdata(array_rdata));
    eeprom_access_control #(.WRITE_RC_COUNT(4)) u_eeprom_access_control (.clk(clk),
        .reset(reset), .rc_osc(rc_osc), .global_irq_enable(global_irq_enable), .cpu_wr(cpu_wr),
        .array_rdata(array_rdata), .array_addr(array_addr), .array_cmd(array_cmd),
        .array_prog(array_prog), .nv_data_reg(nv_data_reg), .nv_address_reg(nv_address_reg),
        .program_mode_field(program_mode_field), .program_arm_bit(program_arm_bit),
        .program_strobe_bit(program_strobe_bit), .ready_irq_enable(ready_irq_enable),
        .ready_irq(ready_irq), .cpu_stall(cpu_stall));
    task close_out;
        $display("errors %0d checks %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task put(input logic [3:0] m, input logic [7:0] d);
        @(negedge clk);
        cpu_wr = {m, d};
        @(negedge clk);
        cpu_wr = '0;
    endtask
    task wait_idle;
        n = 0;
        while (program_strobe_bit !== 1'b0 && n < 200) begin
            @(negedge clk);
            n++;
        end
        chk("idle", program_strobe_bit, 0);
    endtask
    task t_read(input logic [11:0] a);
        wait_idle();
        put(4'h8, {4'h0, a[11:8]});
        put(4'h4, a[7:0]);
        put(4'h1, 8'h01);
        // the stall is already up at the falling edge after the strobe
        n = cpu_stall;
        repeat (7) begin
            @(negedge clk);
            n += cpu_stall;
        end
        chk("stall", n, 4);
        chk("rdata", nv_data_reg, a[7:0] ^ {4'h0, a[11:8]} ^ 8'h5a);
        chk("addr", nv_address_reg, a);
    endtask
    task t_no_arm;
        put(4'h1, 8'h02);
        put(4'h1, 8'h04);
        repeat (4) @(negedge clk);
        chk("armed", program_arm_bit, 1);
        @(negedge clk);
        chk("arm", program_arm_bit, 0);
        put(4'h1, 8'h02);
        repeat (3) @(negedge clk);
        chk("unarmed", program_strobe_bit, 0);
    endtask
    task t_write(input logic [1:0] md, input bit rst);
        wait_idle();
        put(4'h8, 8'h0c);
        put(4'h4, {6'h2a, md});
        put(4'h2, {6'h24, md});
        put(4'h1, {2'h0, md, 4'hc});
        put(4'h1, {2'h0, md, 4'ha});
        // a reset here lands after the write was taken
        reset = rst;
        @(negedge clk);
        reset = 0;
        repeat (2) @(negedge clk);
        chk("busy", program_strobe_bit, 1);
        chk("prog", array_prog, 1);
        chk("cmd", array_cmd, {12'hca8 | md, 6'h24, md, md});
        put(4'h8, 8'h03);
        put(4'h1, 8'h39);
        chk("busy", program_strobe_bit, 1);
        chk("addr", nv_address_reg, 12'hca8 | md);
        chk("data", nv_data_reg, {6'h24, md});
        chk("mode", program_mode_field, md);
        chk("irq", ready_irq, 0);
        wait_idle();
        chk("time", n < 20, 1);
    endtask
    initial begin
        repeat (3) @(negedge clk);
        reset = 0;
        repeat (2) @(negedge clk);
        chk("data0", nv_data_reg, 0);
        chk("mode0", program_mode_field, 0);
        t_read(12'h000);
        t_read(12'hfff);
        t_no_arm();
        for (int i = 0; i < 4; i++) t_write(i[1:0], i == 3);
        t_read(12'h5a3);
        put(4'h1, 8'h08);
        repeat (3) @(negedge clk);
        chk("ready", ready_irq, 1);
        chk("irqen", ready_irq_enable, 1);
        global_irq_enable = 0;
        repeat (3) @(negedge clk);
        chk("masked", ready_irq, 0);
        close_out();
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            close_out();
        end
    end
endmodule

// ===== verification/nv_array_model.sv
// behavioural array answering each address with a fixed pattern
`timescale 1ns/1ps
module nv_array_model (
    input wire logic [nv_access_pkg::ADDR_W-1:0] array_addr, // byte address
    output logic [7:0] array_rdata // byte at that address
);
    import nv_access_pkg::*;
    // both address bytes feed the pattern so a lost high byte shows
    assign array_rdata = array_addr[7:0] ^ {4'h0, array_addr[11:8]} ^ 8'h5a;
endmodule
